// ---- src/sre_core.sv ----
// execution of subroutine exit and rotate-left-through-carry, with apb access
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sre_defs.svh"

// Notes on behaviour
// - the exit opcode 0000 0000 0001 001s pops the return stack into the program counter.
// - with s set, the exit copies the three shadows into accumulator, flags and bank selector.
// - with s clear, the exit leaves accumulator, flags and bank selector as they were.
// - the exit never touches the upper and high program counter latches.
// - opcode 0011 01da ffff ffff is the rotate left through carry on file byte f.
// - the rotate shifts left, bit 7 goes to carry and the old carry enters bit 0.
// - d clear writes the result to the accumulator, d set writes it back to the file.
// - a clear selects the access bank, a set lets the bank selector pick the bank.
// - a clear with the extended set on and f up to 0x5F uses indexed literal offset.
// - the rotate takes one cycle: read in Q2, process in Q3, write in Q4.
module sre_core import sre_pkg::*; (
  input wire logic clock_i,          // core clock, 200 MHz
  input wire logic resetn_i,         // sync reset, active low
  input wire logic psel_i,           // apb select
  input wire logic penable_i,        // apb access phase
  input wire logic pwrite_i,         // apb direction
  input wire logic [7:0] paddr_i,    // apb byte address
  input wire logic [31:0] pwdata_i,  // apb write data
  output logic [31:0] prdata_o,      // apb read data
  output logic pready_o,             // apb ready
  output logic pslverr_o,            // apb error, unmapped address
  output logic busy_o,               // an instruction is executing
  output logic flush_o,              // second, flushing cycle of an exit
  output logic [20:0] fetch_addr_o   // program counter, next fetch address
);
  sre_state_t s_q, s_d;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;
  logic access_x;
  logic mapped_x;
  logic memrd_x;
  logic take_x;
  logic is_ret;
  logic is_rot;
  logic [7:0] f_x;
  logic [11:0] ea_x;
  logic [20:0] top_x;
  logic [4:0] sp_dec;

  assign is_ret = (s_q.op[15:1] == `SRE_RET_PATTERN);
  assign is_rot = (s_q.op[15:10] == `SRE_ROT_PATTERN);
  assign f_x = s_q.op[7:0];
  assign sp_dec = s_q.sp - 5'd1;
  assign top_x = (s_q.sp == 5'd0) ? `SRE_RST_PC : s_q.stack[sp_dec];

  // effective file address of the rotate operand
  always_comb begin
    if (s_q.op[`SRE_OP_A_BIT]) begin
      ea_x = {s_q.bank_selector, f_x};
    end else if (s_q.ext_en && f_x <= `SRE_ILO_LIMIT) begin
      ea_x = s_q.fsr2 + {4'h0, f_x};
    end else if (f_x <= `SRE_ILO_LIMIT) begin
      ea_x = {4'h0, f_x};
    end else begin
      ea_x = {`SRE_ACCESS_HI, f_x};
    end
  end

  // bus decode; writes stall while busy, memory reads until the port settles
  always_comb begin
    access_x = psel_i && penable_i;
    memrd_x = !pwrite_i && (paddr_i == `SRE_OFF_MEMDATA);
    case (paddr_i)
      `SRE_OFF_CTRL, `SRE_OFF_INSTR, `SRE_OFF_STATUS, `SRE_OFF_ACC,
      `SRE_OFF_FLAGS, `SRE_OFF_BANKSEL, `SRE_OFF_ACC_SH, `SRE_OFF_FLAGS_SH,
      `SRE_OFF_BANK_SH, `SRE_OFF_PC, `SRE_OFF_PC_UPPER_LATCH, `SRE_OFF_PC_HIGH_LATCH,
      `SRE_OFF_STACK, `SRE_OFF_SP, `SRE_OFF_IDXBASE, `SRE_OFF_MEMADDR,
      `SRE_OFF_MEMDATA: mapped_x = 1'b1;
      default: mapped_x = 1'b0;
    endcase
    pready_o = !(pwrite_i && busy_o) && !(memrd_x && !(s_q.idle_prev && !busy_o));
    pslverr_o = access_x && pready_o && !mapped_x;
    take_x = access_x && pready_o && mapped_x;
  end

  always_comb begin
    case (paddr_i)
      `SRE_OFF_CTRL: prdata_o = {31'h0, s_q.ext_en};
      `SRE_OFF_INSTR: prdata_o = {16'h0, s_q.op};
      `SRE_OFF_STATUS: prdata_o = {28'h0, s_q.illegal, s_q.oflow, s_q.uflow, busy_o};
      `SRE_OFF_ACC: prdata_o = {24'h0, s_q.acc};
      `SRE_OFF_FLAGS: prdata_o = {24'h0, s_q.flags};
      `SRE_OFF_BANKSEL: prdata_o = {28'h0, s_q.bank_selector};
      `SRE_OFF_ACC_SH: prdata_o = {24'h0, s_q.acc_sh};
      `SRE_OFF_FLAGS_SH: prdata_o = {24'h0, s_q.flags_sh};
      `SRE_OFF_BANK_SH: prdata_o = {28'h0, s_q.bsr_sh};
      `SRE_OFF_PC: prdata_o = {11'h0, s_q.pc};
      `SRE_OFF_PC_UPPER_LATCH: prdata_o = {27'h0, s_q.pc_upper_latch};
      `SRE_OFF_PC_HIGH_LATCH: prdata_o = {24'h0, s_q.pc_high_latch};
      `SRE_OFF_STACK: prdata_o = {11'h0, top_x};
      `SRE_OFF_SP: prdata_o = {27'h0, s_q.sp};
      `SRE_OFF_IDXBASE: prdata_o = {20'h0, s_q.fsr2};
      `SRE_OFF_MEMADDR: prdata_o = {20'h0, s_q.mem_addr};
      `SRE_OFF_MEMDATA: prdata_o = {24'h0, mem_rdata};
      default: prdata_o = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_wdata = s_q.res;
    mem_addr = (s_q.st == SRE_IDLE) ? s_q.mem_addr : s_q.ea;
    s_d.idle_prev = (s_q.st == SRE_IDLE);
    // software writes first so that hardware sets below win
    if (take_x && pwrite_i) begin
      case (paddr_i)
        `SRE_OFF_CTRL: s_d.ext_en = pwdata_i[`SRE_CTRL_EXT];
        `SRE_OFF_INSTR: begin
          s_d.op = pwdata_i[15:0];
          s_d.st = SRE_Q1;
          s_d.cyc2 = 1'b0;
        end
        `SRE_OFF_STATUS: begin
          if (pwdata_i[`SRE_STAT_UFLOW]) s_d.uflow = 1'b0;
          if (pwdata_i[`SRE_STAT_OFLOW]) s_d.oflow = 1'b0;
          if (pwdata_i[`SRE_STAT_ILLEGAL]) s_d.illegal = 1'b0;
        end
        `SRE_OFF_ACC: s_d.acc = pwdata_i[7:0];
        `SRE_OFF_FLAGS: s_d.flags = pwdata_i[7:0];
        `SRE_OFF_BANKSEL: s_d.bank_selector = pwdata_i[3:0];
        `SRE_OFF_ACC_SH: s_d.acc_sh = pwdata_i[7:0];
        `SRE_OFF_FLAGS_SH: s_d.flags_sh = pwdata_i[7:0];
        `SRE_OFF_BANK_SH: s_d.bsr_sh = pwdata_i[3:0];
        `SRE_OFF_PC: s_d.pc = pwdata_i[20:0];
        `SRE_OFF_PC_UPPER_LATCH: s_d.pc_upper_latch = pwdata_i[4:0];
        `SRE_OFF_PC_HIGH_LATCH: s_d.pc_high_latch = pwdata_i[7:0];
        `SRE_OFF_STACK: begin
          if (s_q.sp < `SRE_STACK_DEPTH) begin
            s_d.stack[s_q.sp] = pwdata_i[20:0];
            s_d.sp = s_q.sp + 5'd1;
          end else begin
            s_d.oflow = 1'b1;
          end
        end
        `SRE_OFF_SP: ;
        `SRE_OFF_IDXBASE: s_d.fsr2 = pwdata_i[11:0];
        `SRE_OFF_MEMADDR: s_d.mem_addr = pwdata_i[11:0];
        `SRE_OFF_MEMDATA: begin
          mem_we = 1'b1;
          mem_wdata = pwdata_i[7:0];
        end
        default: ;
      endcase
    end
    case (s_q.st)
      SRE_IDLE: ;
      SRE_Q1: begin
        s_d.st = SRE_Q2;
        if (!s_q.cyc2) begin
          if (is_rot) begin
            s_d.ea = ea_x;
          end else if (!is_ret) begin
            s_d.illegal = 1'b1;
            s_d.st = SRE_IDLE;
          end
        end
      end
      // operand address is on the memory port during Q2
      SRE_Q2: s_d.st = SRE_Q3;
      SRE_Q3: begin
        s_d.st = SRE_Q4;
        if (!s_q.cyc2 && is_rot) begin
          s_d.res = {mem_rdata[6:0], s_q.flags[`SRE_FLAG_C]};
          s_d.cout = mem_rdata[7];
        end
      end
      SRE_Q4: begin
        s_d.st = SRE_IDLE;
        s_d.cyc2 = 1'b0;
        if (!s_q.cyc2 && is_rot) begin
          if (s_q.op[`SRE_OP_D_BIT]) begin
            mem_we = 1'b1;
            mem_wdata = s_q.res;
          end else begin
            s_d.acc = s_q.res;
          end
          s_d.flags[`SRE_FLAG_C] = s_q.cout;
          s_d.flags[`SRE_FLAG_N] = s_q.res[7];
          s_d.flags[`SRE_FLAG_Z] = (s_q.res == 8'h00);
        end else if (!s_q.cyc2 && is_ret) begin
          // latches untouched, only pc takes the popped entry
          s_d.pc = top_x;
          if (s_q.sp == 5'd0) begin
            s_d.uflow = 1'b1;
          end else begin
            s_d.sp = sp_dec;
          end
          if (s_q.op[`SRE_OP_S_BIT]) begin
            s_d.acc = s_q.acc_sh;
            s_d.flags = s_q.flags_sh;
            s_d.bank_selector = s_q.bsr_sh;
          end
          // s clear: nothing written back
          s_d.st = SRE_Q1;
          s_d.cyc2 = 1'b1;
        end
      end
      default: s_d.st = SRE_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.st <= SRE_IDLE;
      s_q.acc <= `SRE_RST_BYTE;
      s_q.flags <= `SRE_RST_BYTE;
      s_q.pc <= `SRE_RST_PC;
    end else begin
      s_q <= s_d;
    end
  end

  sre_file_mem sre_file_mem_inst (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  assign busy_o = (s_q.st != SRE_IDLE);
  assign flush_o = s_q.cyc2;
  assign fetch_addr_o = s_q.pc;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  logic ret_q4;
  logic rot_q3;
  logic rot_q4;
  assign ret_q4 = (s_q.st == SRE_Q4) && !s_q.cyc2 && is_ret;
  assign rot_q3 = (s_q.st == SRE_Q3) && !s_q.cyc2 && is_rot;
  assign rot_q4 = (s_q.st == SRE_Q4) && !s_q.cyc2 && is_rot;

  property p_ret_pop;
    ret_q4 && s_q.sp != 5'd0 |=> s_q.pc == $past(top_x) && s_q.sp == $past(sp_dec);
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("exit did not pop into pc");

  property p_ret_shadow;
    ret_q4 && s_q.op[0] |=> s_q.acc == $past(s_q.acc_sh) && s_q.flags == $past(s_q.flags_sh)
      && s_q.bank_selector == $past(s_q.bsr_sh);
  endproperty
  a_ret_shadow: assert property (p_ret_shadow) else $error("shadows not restored");

  property p_ret_keep;
    ret_q4 && !s_q.op[0] |=> $stable(s_q.acc) && $stable(s_q.flags) && $stable(s_q.bank_selector);
  endproperty
  a_ret_keep: assert property (p_ret_keep) else $error("exit changed working regs");

  property p_latch_keep;
    busy_o |=> $stable(s_q.pc_upper_latch) && $stable(s_q.pc_high_latch);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("pc latch changed");

  property p_ret_two;
    s_q.st == SRE_Q1 && !s_q.cyc2 && is_ret |-> busy_o [*8] ##1 !busy_o;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("exit not two cycles");

  property p_rot_one;
    s_q.st == SRE_Q1 && !s_q.cyc2 && is_rot |-> (busy_o && !flush_o) [*4] ##1 !busy_o;
  endproperty
  a_rot_one: assert property (p_rot_one) else $error("rotate not one cycle");

  property p_rot_acc;
    rot_q3 && !s_q.op[9] |=> ##1
      s_q.acc == {$past(mem_rdata[6:0], 2), $past(s_q.flags[0], 2)}
      && s_q.flags[0] == $past(mem_rdata[7], 2);
  endproperty
  a_rot_acc: assert property (p_rot_acc) else $error("rotate result wrong");

  property p_rot_file;
    rot_q4 && s_q.op[9] |-> mem_we && mem_addr == s_q.ea && mem_wdata == s_q.res;
  endproperty
  a_rot_file: assert property (p_rot_file) else $error("rotate not written back");

  property p_rot_bank;
    s_q.st == SRE_Q2 && is_rot && s_q.op[8] |-> mem_addr == {s_q.bank_selector, s_q.op[7:0]};
  endproperty
  a_rot_bank: assert property (p_rot_bank) else $error("banked address wrong");

  property p_rot_ilo;
    s_q.st == SRE_Q2 && is_rot && !s_q.op[8] && s_q.ext_en && s_q.op[7:0] <= 8'h5F
      |-> mem_addr == s_q.fsr2 + {4'h0, s_q.op[7:0]};
  endproperty
  a_rot_ilo: assert property (p_rot_ilo) else $error("indexed address wrong");

  property p_rot_nz;
    rot_q4 |=> s_q.flags[2] == ($past(s_q.res) == 8'h00) && s_q.flags[4] == $past(s_q.res[7]);
  endproperty
  a_rot_nz: assert property (p_rot_nz) else $error("n or z flag wrong");

  // unknown opcodes spend one quarter and only raise the sticky flag
  property p_ill_op;
    s_q.st == SRE_Q1 && !s_q.cyc2 && !is_rot && !is_ret
      |=> s_q.illegal && !busy_o && $stable(s_q.pc) && $stable(s_q.acc);
  endproperty
  a_ill_op: assert property (p_ill_op) else $error("unknown opcode not flagged");

  property p_ret_empty;
    ret_q4 && s_q.sp == 5'h00 |=> s_q.uflow && s_q.pc == `SRE_RST_PC && s_q.sp == 5'h00;
  endproperty
  a_ret_empty: assert property (p_ret_empty) else $error("empty stack exit wrong");

  property p_flush_len;
    $rose(flush_o) |-> flush_o [*4] ##1 !flush_o;
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("flush cycle length wrong");

  property p_push;
    take_x && pwrite_i && paddr_i == `SRE_OFF_STACK && s_q.sp < `SRE_STACK_DEPTH
      |=> s_q.sp == $past(s_q.sp) + 5'h01 && top_x == $past(pwdata_i[20:0]);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");

  property p_push_full;
    take_x && pwrite_i && paddr_i == `SRE_OFF_STACK && s_q.sp == `SRE_STACK_DEPTH
      |=> s_q.oflow && $stable(s_q.sp);
  endproperty
  a_push_full: assert property (p_push_full) else $error("full stack push wrong");

  // nothing moves the working registers between instructions but a bus write
  property p_idle_quiet;
    !busy_o && !(access_x && pwrite_i)
      |=> $stable(s_q.acc) && $stable(s_q.flags) && $stable(s_q.pc);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("state moved while idle");

  c_ret_shadow: cover property (ret_q4 && s_q.op[0]);
  c_rot_acc: cover property (rot_q4 && !s_q.op[9]);
  c_rot_ilo: cover property (rot_q4 && !s_q.op[8] && s_q.ext_en && s_q.op[7:0] <= 8'h5F);
  c_mem_wait: cover property (access_x && memrd_x && !pready_o);
  c_ret_empty: cover property (ret_q4 && s_q.sp == 5'h00);
endmodule
`default_nettype wire

// ---- src/sre_defs.svh ----
// constants for the subroutine-exit and rotate execution block
`ifndef SRE_DEFS_SVH
`define SRE_DEFS_SVH

// register byte addresses on the apb bus
`define SRE_OFF_CTRL      8'h00
`define SRE_OFF_INSTR     8'h04
`define SRE_OFF_STATUS    8'h08
`define SRE_OFF_ACC       8'h0C
`define SRE_OFF_FLAGS     8'h10
`define SRE_OFF_BANKSEL   8'h14
`define SRE_OFF_ACC_SH    8'h18
`define SRE_OFF_FLAGS_SH  8'h1C
`define SRE_OFF_BANK_SH   8'h20
`define SRE_OFF_PC        8'h24
`define SRE_OFF_PC_UPPER_LATCH    8'h28
`define SRE_OFF_PC_HIGH_LATCH    8'h2C
`define SRE_OFF_STACK     8'h30
`define SRE_OFF_SP        8'h34
`define SRE_OFF_IDXBASE   8'h38
`define SRE_OFF_MEMADDR   8'h3C
`define SRE_OFF_MEMDATA   8'h40

// field positions
`define SRE_CTRL_EXT      0
`define SRE_STAT_BUSY     0
`define SRE_STAT_UFLOW    1
`define SRE_STAT_OFLOW    2
`define SRE_STAT_ILLEGAL  3
`define SRE_FLAG_C        0
`define SRE_FLAG_Z        2
`define SRE_FLAG_N        4

// opcode patterns
`define SRE_RET_PATTERN   15'h0009
`define SRE_ROT_PATTERN   6'h0D
`define SRE_OP_S_BIT      0
`define SRE_OP_A_BIT      8
`define SRE_OP_D_BIT      9
`define SRE_ILO_LIMIT     8'h5F
`define SRE_ACCESS_HI     4'hF

// sizes and timing
`define SRE_STACK_DEPTH   5'h1F
`define SRE_Q_PER_CYCLE   4
`define SRE_RST_BYTE      8'h00
`define SRE_RST_PC        21'h000000

`endif

// ---- src/sre_file_mem.sv ----
// data memory of file registers, read data registered
`timescale 1ns/100ps
`default_nettype none
module sre_file_mem (
  input wire logic clock_i,         // core clock
  input wire logic resetn_i,        // sync reset, active low
  input wire logic we_i,            // write strobe
  input wire logic [11:0] addr_i,   // byte address
  input wire logic [7:0] wdata_i,   // write data
  output logic [7:0] rdata_o        // data at address of last edge
);
  logic [7:0] mem [0:4095];
  logic [7:0] rdata_q;

  // array left without reset, as a real file ram would be
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // read-before-write on a colliding edge
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem[addr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ---- src/sre_pkg.sv ----
// types for the subroutine-exit and rotate execution block
package sre_pkg;

  typedef enum logic [4:0] {
    SRE_IDLE = 5'b00001,
    SRE_Q1   = 5'b00010,
    SRE_Q2   = 5'b00100,
    SRE_Q3   = 5'b01000,
    SRE_Q4   = 5'b10000
  } sre_phase_t;

  typedef struct packed {
    sre_phase_t st;
    logic cyc2;
    logic [15:0] op;
    logic [11:0] ea;
    logic [7:0] res;
    logic cout;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [3:0] bank_selector;
    logic [7:0] acc_sh;
    logic [7:0] flags_sh;
    logic [3:0] bsr_sh;
    logic [20:0] pc;
    logic [4:0] pc_upper_latch;
    logic [7:0] pc_high_latch;
    logic [30:0][20:0] stack;
    logic [4:0] sp;
    logic ext_en;
    logic [11:0] fsr2;
    logic [11:0] mem_addr;
    logic uflow;
    logic oflow;
    logic illegal;
    logic idle_prev;
  } sre_state_t;

endpackage

// ---- tb/tb_sre_core.sv ----
// self-checking bench for the subroutine-exit and rotate execution block
`timescale 1ns/100ps
`default_nettype none
`include "sre_defs.svh"
module tb_sre_core;
  typedef struct packed {logic [31:0] d; logic e;} sre_note_t;
  logic clock_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, busy_o, flush_o;
  logic [20:0] fetch_addr_o;
  sre_note_t note_q[$];
  sre_note_t nt;
  int err_count = 0;
  int checked = 0;
  int busy_cnt = 0;
  int flush_cnt = 0;
  logic [7:0] f, v, fl, ac, res, efl, sa, sf, lh;
  logic [3:0] bk, sb;
  logic [4:0] lu;
  logic [11:0] ib, ea;
  logic [20:0] r;
  logic d, a, ext, s;

  sre_core sre_core_inst (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
    .flush_o(flush_o), .fetch_addr_o(fetch_addr_o));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // holds the whole request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= dt;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      print_verdict();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt);
  endtask

  // the expectation is noted first; the monitor compares when data shows
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic er = 1'b0);
    note_q.push_back({e, er});
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic run(input logic [15:0] op);
    int n;
    busy_cnt = 0;
    flush_cnt = 0;
    wr(`SRE_OFF_INSTR, {16'h0, op});
    n = 0;
    while (busy_o !== 1'b0 && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      print_verdict();
    end
  endtask

  always @(posedge clock_i) begin
    if (busy_o === 1'b1) busy_cnt++;
    if (flush_o === 1'b1) flush_cnt++;
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      if (note_q.size() == 0) begin
        err_count++;
        $display("unexpected read with no expectation noted");
      end else begin
        nt = note_q.pop_front();
        cmp("prdata", nt.d, prdata_o);
        cmp("pslverr", {31'h0, nt.e}, {31'h0, pslverr_o});
      end
    end
  end

  initial begin
    repeat (50000) @(posedge clock_i);
    err_count++;
    print_verdict();
  end

  initial begin
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    void'($urandom(11996));
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    rd(`SRE_OFF_PC, 32'h0);
    rd(`SRE_OFF_SP, 32'h0);
    rd(8'h44, 32'h0, 1'b1);
    // exit with and without shadow restore; fresh values each pass
    for (int k = 0; k < 2; k++) begin
      s = (k == 0);
      r = 21'($urandom);
      {ac, fl, sa, sf, lh} = 40'({$urandom, $urandom});
      {bk, sb, lu} = 13'($urandom);
      wr(`SRE_OFF_STACK, {11'h0, r});
      wr(`SRE_OFF_ACC, {24'h0, ac});
      wr(`SRE_OFF_FLAGS, {24'h0, fl});
      wr(`SRE_OFF_BANKSEL, {28'h0, bk});
      wr(`SRE_OFF_ACC_SH, {24'h0, sa});
      wr(`SRE_OFF_FLAGS_SH, {24'h0, sf});
      wr(`SRE_OFF_BANK_SH, {28'h0, sb});
      wr(`SRE_OFF_PC_UPPER_LATCH, {27'h0, lu});
      wr(`SRE_OFF_PC_HIGH_LATCH, {24'h0, lh});
      rd(`SRE_OFF_SP, 32'h1);
      run({15'h0009, s});
      cmp("exit busy", 32'd8, 32'(busy_cnt));
      cmp("flush", 32'd4, 32'(flush_cnt));
      cmp("fetch addr", {11'h0, r}, {11'h0, fetch_addr_o});
      rd(`SRE_OFF_PC, {11'h0, r});
      rd(`SRE_OFF_SP, 32'h0);
      rd(`SRE_OFF_ACC, {24'h0, s ? sa : ac});
      rd(`SRE_OFF_FLAGS, {24'h0, s ? sf : fl});
      rd(`SRE_OFF_BANKSEL, {28'h0, s ? sb : bk});
      rd(`SRE_OFF_PC_UPPER_LATCH, {27'h0, lu});
      rd(`SRE_OFF_PC_HIGH_LATCH, {24'h0, lh});
    end
    // every d, a, extended-set combination on both sides of the 0x5F split
    for (int j = 0; j < 16; j++) begin
      d = j[0];
      a = j[1];
      ext = j[2];
      f = j[3] ? 8'h60 + 8'($urandom % 160) : 8'($urandom % 96);
      if (j == 4) f = 8'h5F;
      if (j == 12) f = 8'h60;
      {v, fl, ac, bk, ib} = 40'({$urandom, $urandom});
      if (j == 1) begin
        v = 8'h80;
        fl[0] = 1'b0;
      end
      if (!a && ext && f <= 8'h5F) ea = ib + {4'h0, f};
      else if (!a) ea = {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
      else ea = {bk, f};
      wr(`SRE_OFF_CTRL, {31'h0, ext});
      wr(`SRE_OFF_FLAGS, {24'h0, fl});
      wr(`SRE_OFF_BANKSEL, {28'h0, bk});
      wr(`SRE_OFF_IDXBASE, {20'h0, ib});
      wr(`SRE_OFF_ACC, {24'h0, ac});
      wr(`SRE_OFF_MEMADDR, {20'h0, ea});
      wr(`SRE_OFF_MEMDATA, {24'h0, v});
      res = {v[6:0], fl[0]};
      efl = (fl & 8'hEA) | {3'h0, res[7], 1'b0, res == 8'h00, 1'b0, v[7]};
      run({6'h0D, d, a, f});
      cmp("rotate busy", 32'd4, 32'(busy_cnt));
      rd(`SRE_OFF_FLAGS, {24'h0, efl});
      rd(`SRE_OFF_ACC, {24'h0, d ? ac : res});
      rd(`SRE_OFF_MEMDATA, {24'h0, d ? res : v});
    end
    // unknown opcode, exit on an empty stack, then a stack pushed past full
    run(16'hFFFF);
    cmp("illegal busy", 32'h1, 32'(busy_cnt));
    rd(`SRE_OFF_STATUS, 32'h8);
    wr(`SRE_OFF_STATUS, 32'h8);
    run(16'h0012);
    cmp("empty exit pc", 32'h0, {11'h0, fetch_addr_o});
    rd(`SRE_OFF_STATUS, 32'h2);
    rd(`SRE_OFF_SP, 32'h0);
    for (int k = 0; k < 32; k++) begin
      wr(`SRE_OFF_STACK, {11'h0, 21'(k)});
    end
    rd(`SRE_OFF_SP, 32'h1F);
    rd(`SRE_OFF_STATUS, 32'h6);
    rd(`SRE_OFF_STACK, 32'h1E);
    wr(`SRE_OFF_STATUS, 32'h6);
    rd(`SRE_OFF_STATUS, 32'h0);
    repeat (2) @(posedge clock_i);
    print_verdict();
  end
endmodule
`default_nettype wire
